// file: logic/e1cv_pkg.sv
// constants and types of the coding violation counter bank
package e1cv_pkg;

	// ********************************************
	// sizes
	// ********************************************
	localparam int PORTS  = 4;
	localparam int CNT_W  = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 12;
	localparam int IDX_W  = 10;
	localparam int PEND_W = 4;
	localparam int DATA_W = 32;

	// ********************************************
	// register indices, byte address is index * 4
	// ********************************************
	localparam logic [IDX_W-1:0] IDX_CNT_LOW [PORTS] =
		'{10'h046, 10'h076, 10'h0A6, 10'h0D6};
	localparam logic [IDX_W-1:0] IDX_CNT_HIGH [PORTS] =
		'{10'h047, 10'h077, 10'h0A7, 10'h0D7};
	localparam logic [IDX_W-1:0] IDX_OPER [PORTS] =
		'{10'h048, 10'h078, 10'h0A8, 10'h0D8};
	localparam logic [IDX_W-1:0] IDX_CLEAR = 10'h0F0;

	// ********************************************
	// field positions and reset values
	// ********************************************
	localparam int BIT_REMOTE_DEFECT = 4;
	localparam int BIT_TX_ENABLE     = 3;
	localparam int BIT_SEG_SIZE      = 2;
	localparam int BIT_COMPARE       = 1;
	localparam int BIT_ALARM_ENABLE  = 0;
	localparam int OPER_USED_W       = 5;
	localparam int BIT_GLOBAL_RESET  = 0;
	localparam int BASE_CLEAR_S      = 1;
	localparam int BASE_CLEAR_C      = 5;
	localparam int CLEAR_W           = 9;
	localparam logic [OPER_USED_W-1:0] OPER_RESET = 5'h00;
	localparam logic [CLEAR_W-1:0]     CLEAR_RESET = 9'h000;
	localparam logic [BYTE_W-1:0]      J2_IDLE_BYTE = 8'h00;

	// ********************************************
	// per-port control outputs
	// ********************************************
	typedef struct packed {
		logic remote_defect_mode;
		logic trace_tx_enable;
		logic trace_segment_size;
		logic trace_compare_enable;
		logic trace_alarm_enable;
	} e1cv_port_ctrl_type;

endpackage : e1cv_pkg

// file: logic/e1cv_counter.sv
// one port's saturating violation counter with read hold-off
`timescale 1ns/1ps
`default_nettype none
module e1cv_counter #(
	parameter int CNT_W  = e1cv_pkg::CNT_W,
	parameter int PEND_W = e1cv_pkg::PEND_W
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             violation,
	input  wire logic             hold,
	input  wire logic             clear,
	output logic      [CNT_W-1:0] count
);

	// ********************************************
	// state
	// ********************************************
	logic [CNT_W-1:0]  count_ff;
	logic [CNT_W-1:0]  nxt_count;
	logic [PEND_W-1:0] pend_ff;
	logic [PEND_W-1:0] nxt_pend;
	logic [CNT_W:0]    sum;
	logic [PEND_W:0]   pend_sum;

	localparam logic [CNT_W:0]  CNT_MAX  = {1'b0, {CNT_W{1'b1}}};
	localparam logic [PEND_W:0] PEND_MAX = {1'b0, {PEND_W{1'b1}}};

	// ********************************************
	// next values
	// ********************************************
	assign sum      = {1'b0, count_ff} + CNT_W'(pend_ff) + CNT_W'(violation);
	assign pend_sum = {1'b0, pend_ff} + PEND_W'(violation);

	// events seen during a read wait in pend_ff, then fold in [RQ2]
	assign nxt_pend = hold ? ((pend_sum > PEND_MAX) ? PEND_MAX[PEND_W-1:0]
		: pend_sum[PEND_W-1:0]) : '0; // [RQ2]

	// saturate instead of wrapping [RQ1]
	assign nxt_count = clear ? '0 // [RQ3]
		: hold ? count_ff // [RQ2]
		: (sum > CNT_MAX) ? CNT_MAX[CNT_W-1:0] : sum[CNT_W-1:0]; // [RQ1]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= '0; // [RQ3]
			pend_ff  <= '0;
		end else begin
			count_ff <= nxt_count;
			pend_ff  <= nxt_pend;
		end
	end

	assign count = count_ff;

endmodule : e1cv_counter
`default_nettype wire

// file: logic/e1cv_bank.sv
// four-port coding violation counters and operation control, apb slave
//
// Functional notes
// [RQ1] per-port 16-bit saturating violation counter
// [RQ2] events during counter read deferred, not lost
// [RQ3] clear on reset, control bits, low read
// [RQ4] low read copies high byte to snapshot
// [RQ5] host reads low byte then high byte
// [RQ6] low byte sits just below high byte
// [RQ7] trace enable selects ram message or zeros
// [RQ8] host writes zero to operation bits 7-5
// [RQ9] size bit picks 16 or 64 byte segments
// [RQ10] independent port instances, shared snapshot only
`timescale 1ns/1ps
`default_nettype none
module e1cv_bank #(
	parameter int PORTS = e1cv_pkg::PORTS
) (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [e1cv_pkg::ADDR_W-1:0]            paddr,
	input  wire logic [e1cv_pkg::DATA_W-1:0]            pwdata,
	input  wire logic [3:0]                             pstrb,
	output logic      [e1cv_pkg::DATA_W-1:0]            prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic [PORTS-1:0]                       violation,
	input  wire logic [PORTS-1:0][e1cv_pkg::BYTE_W-1:0] j2_ram_byte,
	output logic      [PORTS-1:0][e1cv_pkg::BYTE_W-1:0] j2_tx_byte,
	output logic      [PORTS-1:0]                       j2_seg_64,
	output logic      [PORTS-1:0]                       j2_compare_on,
	output e1cv_pkg::e1cv_port_ctrl_type [PORTS-1:0]    port_ctrl
);

	// ********************************************
	// bus phases and decode
	// ********************************************
	localparam int IDX_W  = e1cv_pkg::IDX_W;
	localparam int BYTE_W = e1cv_pkg::BYTE_W;
	localparam int CNT_W  = e1cv_pkg::CNT_W;
	localparam int OPW    = e1cv_pkg::OPER_USED_W;
	localparam int CLW    = e1cv_pkg::CLEAR_W;
	localparam int DATA_W = e1cv_pkg::DATA_W;

	logic             setup_ph;
	logic             access_ph;
	logic             aligned;
	logic [IDX_W-1:0] idx;
	logic             hit_clear;
	logic             any_hit;
	logic             rd_done;
	logic             wr_done;

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign aligned   = (paddr[1:0] == 2'b00);
	assign idx       = paddr[e1cv_pkg::ADDR_W-1:2];
	assign hit_clear = aligned & (idx == e1cv_pkg::IDX_CLEAR);
	assign rd_done   = access_ph & ~pwrite;
	assign wr_done   = access_ph & pwrite & pstrb[0];

	// ********************************************
	// per-port decode
	// ********************************************
	logic [PORTS-1:0] hit_low;
	logic [PORTS-1:0] hit_high;
	logic [PORTS-1:0] hit_oper;
	logic [PORTS-1:0] rd_low_done;
	logic [PORTS-1:0] rd_hold;
	logic [PORTS-1:0] wr_oper;
	logic [PORTS-1:0] cnt_clear;

	// ********************************************
	// registers
	// ********************************************
	logic [PORTS-1:0][OPW-1:0]   oper_ff;
	logic [PORTS-1:0][OPW-1:0]   nxt_oper;
	logic [CLW-1:0]              clear_ff;
	logic [CLW-1:0]              nxt_clear;
	logic [BYTE_W-1:0]           snap_ff;
	logic [BYTE_W-1:0]           nxt_snap;
	logic [DATA_W-1:0]           prdata_ff;
	logic [DATA_W-1:0]           nxt_prdata;
	logic [PORTS-1:0][CNT_W-1:0] count;
	logic [PORTS-1:0][BYTE_W-1:0] j2_ff;
	logic [PORTS-1:0][BYTE_W-1:0] nxt_j2;
	logic [PORTS-1:0][DATA_W-1:0] port_rd;
	logic                        global_reset;

	assign global_reset = clear_ff[e1cv_pkg::BIT_GLOBAL_RESET];

	genvar g;
	generate
		for (g = 0; g < PORTS; g++) begin : g_port
			// high byte index is the low index plus one [RQ6]
			assign hit_low[g]  = aligned
				& (idx == e1cv_pkg::IDX_CNT_LOW[g]); // [RQ6]
			assign hit_high[g] = aligned
				& (idx == e1cv_pkg::IDX_CNT_HIGH[g]); // [RQ6]
			assign hit_oper[g] = aligned
				& (idx == e1cv_pkg::IDX_OPER[g]);

			assign rd_low_done[g] = rd_done & hit_low[g];
			assign wr_oper[g]     = wr_done & hit_oper[g];

			// whole read cycle, setup and access, freezes the count [RQ2]
			assign rd_hold[g] = psel & ~pwrite
				& (hit_low[g] | hit_high[g]); // [RQ2]

			// control bits hold the counter at zero while set
			assign cnt_clear[g] = global_reset
				| clear_ff[e1cv_pkg::BASE_CLEAR_S + g]
				| clear_ff[e1cv_pkg::BASE_CLEAR_C + g]
				| rd_low_done[g]; // [RQ3]

			// each port owns its counter and control register [RQ10]
			e1cv_counter #(
				.CNT_W  (CNT_W),
				.PEND_W (e1cv_pkg::PEND_W)
			) u_counter (
				.pclk      (pclk),
				.presetn   (presetn),
				.violation (violation[g]),
				.hold      (rd_hold[g]),
				.clear     (cnt_clear[g]),
				.count     (count[g])
			); // [RQ10] [RQ1]

			// bits 7-5 are dropped, host keeps them zero [RQ8]
			assign nxt_oper[g] = wr_oper[g] ? pwdata[OPW-1:0] : oper_ff[g];

			// high byte reads the shared snapshot, not the live count [RQ4]
			assign port_rd[g] =
				hit_low[g]  ? DATA_W'(count[g][BYTE_W-1:0])
				: hit_high[g] ? DATA_W'(snap_ff) // [RQ4]
				: hit_oper[g] ? DATA_W'(oper_ff[g])
				: '0;

			// zeros go out when the message is disabled [RQ7]
			assign nxt_j2[g] = oper_ff[g][e1cv_pkg::BIT_TX_ENABLE]
				? j2_ram_byte[g] : e1cv_pkg::J2_IDLE_BYTE; // [RQ7]

			assign port_ctrl[g].remote_defect_mode =
				oper_ff[g][e1cv_pkg::BIT_REMOTE_DEFECT];
			assign port_ctrl[g].trace_tx_enable =
				oper_ff[g][e1cv_pkg::BIT_TX_ENABLE];
			assign port_ctrl[g].trace_segment_size =
				oper_ff[g][e1cv_pkg::BIT_SEG_SIZE];
			assign port_ctrl[g].trace_compare_enable =
				oper_ff[g][e1cv_pkg::BIT_COMPARE];
			assign port_ctrl[g].trace_alarm_enable =
				oper_ff[g][e1cv_pkg::BIT_ALARM_ENABLE];

			// 64-byte segments switch comparison off; the alarm enable passes through ungated [RQ9]
			assign j2_seg_64[g] = oper_ff[g][e1cv_pkg::BIT_SEG_SIZE]; // [RQ9]
			assign j2_compare_on[g] = ~oper_ff[g][e1cv_pkg::BIT_SEG_SIZE]
				& oper_ff[g][e1cv_pkg::BIT_COMPARE]; // [RQ9]
		end
	endgenerate

	assign any_hit = hit_clear | (|hit_low) | (|hit_high) | (|hit_oper);

	// ********************************************
	// shared snapshot and read data
	// ********************************************
	// one location serves all ports, so a second low read clobbers it
	always_comb begin
		nxt_snap   = snap_ff;
		nxt_prdata = prdata_ff;
		for (int i = 0; i < PORTS; i++) begin
			if (rd_low_done[i]) begin
				nxt_snap = count[i][CNT_W-1:BYTE_W]; // [RQ4]
			end
		end
		// sampled in setup; the count is already frozen then
		if (setup_ph & ~pwrite) begin
			nxt_prdata = hit_clear ? DATA_W'(clear_ff) : '0;
			for (int i = 0; i < PORTS; i++) begin
				nxt_prdata = nxt_prdata | port_rd[i];
			end
		end
	end

	assign nxt_clear = (wr_done & hit_clear) ? pwdata[CLW-1:0] : clear_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_ff  <= e1cv_pkg::CLEAR_RESET;
			snap_ff   <= '0;
			prdata_ff <= '0;
		end else begin
			clear_ff  <= nxt_clear;
			snap_ff   <= nxt_snap;
			prdata_ff <= nxt_prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PORTS; i++) begin
				oper_ff[i] <= e1cv_pkg::OPER_RESET;
				j2_ff[i]   <= e1cv_pkg::J2_IDLE_BYTE;
			end
		end else begin
			oper_ff <= nxt_oper;
			j2_ff   <= nxt_j2;
		end
	end

	// ********************************************
	// outputs
	// ********************************************
	// no wait states: every access ends in its first access cycle
	assign pready     = 1'b1;
	assign pslverr    = access_ph & ~any_hit;
	assign prdata     = prdata_ff;
	assign j2_tx_byte = j2_ff;

endmodule : e1cv_bank
`default_nettype wire

// file: verification/e1cv_bank_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module e1cv_bank_checker #(
	parameter int PORTS = 4
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [PORTS-1:0][7:0]  j2_ram_byte,
	input wire logic [PORTS-1:0][7:0]  j2_tx_byte,
	input wire logic [PORTS-1:0]       j2_seg_64,
	input wire logic [PORTS-1:0]       j2_compare_on,
	input wire e1cv_pkg::e1cv_port_ctrl_type [PORTS-1:0] port_ctrl
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel & penable;
	sequence s_oper0_wr;
		acc && pwrite && pstrb[0] && paddr == 12'h120;
	endsequence
	a_oper_load: assert property (
		s_oper0_wr |=> port_ctrl[0] == $past(pwdata[4:0]))
		else $error("control write lost");
	a_other_port: assert property (
		s_oper0_wr |=> port_ctrl[1] == $past(port_ctrl[1]))
		else $error("write leaked to next port");
	a_misalign_err: assert property (
		acc && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access accepted");
	a_idle_no_err: assert property (!acc |-> !pslverr)
		else $error("error outside access");
	// writes leave prdata at the last read value, so only reads are held
	a_err_data: assert property (
		acc && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("data on refused read");
	a_no_wait: assert property (acc |-> pready)
		else $error("wait state inserted");
	for (genvar i = 0; i < PORTS; i++) begin : g_port
		a_seg_level: assert property (
			j2_seg_64[i] == port_ctrl[i].trace_segment_size)
			else $error("segment size mismatch");
		a_cmp_gate: assert property (j2_compare_on[i] ==
			(port_ctrl[i].trace_compare_enable
			& ~port_ctrl[i].trace_segment_size))
			else $error("compare gating wrong");
		a_tx_source: assert property (1'b1 |=> j2_tx_byte[i] ==
			($past(port_ctrl[i].trace_tx_enable)
			? $past(j2_ram_byte[i]) : 8'h00))
			else $error("j2 byte source wrong");
	end
endmodule : e1cv_bank_checker
`default_nettype wire

// file: verification/e1cv_host.sv
// apb host model for the register bank
`timescale 1ns/1ps
`default_nettype none
module e1cv_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ****************
	// bus cycles
	// ****************
	logic hung = 1'b0;
	// lane pattern of the next transfer, all lanes unless a test says so
	logic [3:0] strb = 4'hF;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// bounded wait: a stuck slave must not hang the run
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= strb;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		hung = hung | (n == 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// high byte only valid right after its own low byte
	task automatic rd_pair(input int p, output logic [31:0] lo, hi);
		logic e;
		xfer(1'b0, {e1cv_pkg::IDX_CNT_LOW[p], 2'b00}, 32'h0, lo, e);
		xfer(1'b0, {e1cv_pkg::IDX_CNT_HIGH[p], 2'b00}, 32'h0, hi, e);
	endtask : rd_pair
	task automatic wr_oper(input int p, input logic [7:0] v);
		logic [31:0] d;
		logic e;
		xfer(1'b1, {e1cv_pkg::IDX_OPER[p], 2'b00}, {27'h0, v[4:0]}, d, e);
	endtask : wr_oper
endmodule : e1cv_host
`default_nettype wire

// file: verification/test_e1_code_violation_counter_j2_ctrl.sv
// self-checking bench of the violation counter bank
`timescale 1ns/1ps
`default_nettype none
bind e1cv_bank e1cv_bank_checker #(.PORTS(PORTS)) chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.j2_ram_byte(j2_ram_byte),
	.j2_tx_byte(j2_tx_byte), .j2_seg_64(j2_seg_64),
	.j2_compare_on(j2_compare_on), .port_ctrl(port_ctrl));
module test_e1_code_violation_counter_j2_ctrl;
	// ****************
	// bench
	// ****************
	localparam logic [11:0] LO0 = {e1cv_pkg::IDX_CNT_LOW[0], 2'b00};
	localparam logic [11:0] CLR = {e1cv_pkg::IDX_CLEAR, 2'b00};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [3:0] violation = 4'h0;
	logic [3:0][7:0] j2_ram_byte = '0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, j2_seg_64, j2_compare_on;
	logic [3:0][7:0] j2_tx_byte;
	e1cv_pkg::e1cv_port_ctrl_type [3:0] port_ctrl;
	int err_total = 0;
	int samples_checked = 0;
	always #20 pclk = ~pclk;
	e1cv_host host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	e1cv_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.violation(violation), .j2_ram_byte(j2_ram_byte),
		.j2_tx_byte(j2_tx_byte), .j2_seg_64(j2_seg_64),
		.j2_compare_on(j2_compare_on), .port_ctrl(port_ctrl));
	task automatic summarize();
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	always @(posedge pclk)
		if (host.hung === 1'b1) begin
			err_total++;
			summarize();
		end
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic pulse(input int n [4], input int len);
		for (int k = 0; k < len; k++) begin
			@(posedge pclk);
			for (int i = 0; i < 4; i++)
				violation[i] <= (k < n[i]);
		end
		@(posedge pclk);
		violation <= 4'h0;
		@(posedge pclk);
	endtask : pulse
	task automatic t_count();
		logic [31:0] lo, hi;
		logic e;
		int n [4] = '{300, 600, 900, 1200};
		host.rd_pair(0, lo, hi);
		check("count after reset", {hi[7:0], lo[7:0]}, 32'h0);
		pulse(n, 1200);
		for (int p = 0; p < 4; p++) begin
			host.rd_pair(p, lo, hi);
			check("count low", lo, n[p] & 32'hFF);
			check("count high", hi, n[p] >> 8);
		end
		host.xfer(1'b0, {e1cv_pkg::IDX_CNT_HIGH[0], 2'b00}, 32'h0, hi, e);
		check("shared snapshot", hi, 32'h4);
		for (int p = 0; p < 4; p++) begin
			host.rd_pair(p, lo, hi);
			check("cleared by read", {hi[7:0], lo[7:0]}, 32'h0);
		end
	endtask : t_count
	task automatic t_defer();
		logic [31:0] d;
		logic e;
		host.xfer(1'b0, LO0, 32'h0, d, e);
		fork
			host.xfer(1'b0, LO0, 32'h0, d, e);
			begin
				@(posedge pclk);
				violation[0] <= 1'b1;
				repeat (2) @(posedge pclk);
				violation[0] <= 1'b0;
			end
		join
		check("read of cleared count", d, 32'h0);
		repeat (2) @(posedge pclk);
		host.xfer(1'b0, LO0, 32'h0, d, e);
		check("deferred events", d, 32'h2);
	endtask : t_defer
	task automatic t_clear();
		logic [31:0] lo, hi, d;
		logic e;
		int n [4];
		int q;
		// long run to the ceiling, then one clear per control bit
		pulse('{0, 0, 0, 65540}, 65540);
		host.rd_pair(3, lo, hi);
		check("saturated", {hi[7:0], lo[7:0]}, 32'hFFFF);
		for (int b = 0; b < 9; b++) begin
			q = (b == 0) ? 0 : (b - 1) % 4;
			n = '{0, 0, 0, 0};
			n[q] = 5;
			pulse(n, 5);
			host.xfer(1'b1, CLR, 32'h1 << b, d, e);
			host.xfer(1'b1, CLR, 32'h0, d, e);
			host.rd_pair(q, lo, hi);
			check("control clear", {hi[7:0], lo[7:0]}, 32'h0);
		end
	endtask : t_clear
	task automatic t_oper();
		logic [31:0] d;
		logic e;
		logic [4:0] v;
		logic [4:0] last [4] = '{5'h0, 5'h0, 5'h0, 5'h0};
		int p;
		for (int k = 0; k < 32; k++) begin
			p = k % 4;
			v = k[4:0];
			j2_ram_byte[p] <= 8'h5A ^ 8'(k);
			host.wr_oper(p, {3'b000, v});
			repeat (2) @(posedge pclk);
			#1;
			check("control fields", port_ctrl[p], v);
			check("segment size", j2_seg_64[p], v[2]);
			check("compare gate", j2_compare_on[p], v[1] & ~v[2]);
			check("j2 byte", j2_tx_byte[p], v[3] ? 8'h5A ^ 8'(k) : 8'h0);
			check("other port", port_ctrl[(p + 1) % 4], last[(p + 1) % 4]);
			last[p] = v;
			host.xfer(1'b0, {e1cv_pkg::IDX_OPER[p], 2'b00}, 32'h0, d, e);
			check("control readback", d, v);
		end
		// byte lane 0 off: the write must leave the register alone
		host.strb = 4'hE;
		host.wr_oper(0, 8'h00);
		host.strb = 4'hF;
		host.xfer(1'b0, {e1cv_pkg::IDX_OPER[0], 2'b00}, 32'h0, d, e);
		check("strobe off write", d, last[0]);
		host.xfer(1'b0, 12'h004, 32'h0, d, e);
		check("unmapped error", e, 1'b1);
		check("unmapped data", d, 32'h0);
		host.xfer(1'b0, 12'h119, 32'h0, d, e);
		check("misaligned error", e, 1'b1);
	endtask : t_oper
	task automatic t_reset();
		logic [31:0] lo, hi;
		// second reset in mid-run with live controls and counts
		pulse('{3, 3, 3, 3}, 3);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check("reset controls again", port_ctrl, 32'h0);
		check("reset j2 bytes", j2_tx_byte, 32'h0);
		for (int p = 0; p < 4; p++) begin
			host.rd_pair(p, lo, hi);
			check("reset counts", {hi[7:0], lo[7:0]}, 32'h0);
		end
	endtask : t_reset
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		check("reset controls", port_ctrl, 32'h0);
		t_count();
		t_defer();
		t_clear();
		t_oper();
		t_reset();
		summarize();
	end
endmodule : test_e1_code_violation_counter_j2_ctrl
`default_nettype wire
